// *** rtl/usu_defines.vh ***
// usu_defines.vh: offsets, field positions, reset values and timing counts
// assumes: included by the serial port design files, 32-bit axi4-lite word map
`ifndef USU_DEFINES_VH
`define USU_DEFINES_VH

// register indexes as printed; byte address is four times the index
`define USU_IDX_CTRL0   8'h95
`define USU_IDX_BAUDL0  8'h9d
`define USU_IDX_BAUDH0  8'h9e
`define USU_IDX_DATA0   8'h9f
`define USU_IDX_CTRL1   8'ha4
`define USU_IDX_BAUDL1  8'ha5
`define USU_IDX_BAUDH1  8'ha6
`define USU_IDX_DATA1   8'ha7
`define USU_IDX_CTRL2   8'hc4
`define USU_IDX_BAUDL2  8'hc5
`define USU_IDX_BAUDH2  8'hc6
`define USU_IDX_DATA2   8'hc7
// function select register, two bits per channel
`define USU_IDX_FSEL    8'hd0

// control field positions
`define USU_B_FMT_HI    7
`define USU_B_FMT_LO    6
`define USU_B_FILT      5
`define USU_B_RXEN      4
`define USU_B_TX9       3
`define USU_B_RX9       2
`define USU_B_TXDONE    1
`define USU_B_RXDONE    0

`define USU_FSEL_UART   2'h3
`define USU_FMT_SYNC    2'h0
`define USU_FMT_TEN     2'h1
`define USU_FMT_ELEVEN  2'h3

`define USU_RST_BYTE    8'h00
// synchronous shift rate dividers
`define USU_SYNC_DIV_SLOW 16'h000c
`define USU_SYNC_DIV_FAST 16'h0004
// axi response codes
`define USU_RESP_OKAY   2'h0
`define USU_RESP_SLVERR 2'h2

`endif

// *** rtl/usu_channel.v ***
// usu_channel.v: one serial channel (sync shift, 10-bit and 11-bit async)
// assumes: single clock, control bits held by the register file above
`timescale 1ns/100ps
`default_nettype none
`include "usu_defines.vh"

module usu_channel
(
  input  wire        i_ref_clk,
  input  wire        i_rst,
  input  wire        i_active,
  input  wire [1:0]  i_fmt,
  input  wire        i_filt,
  input  wire        i_rxen,
  input  wire        i_tx9,
  input  wire [15:0] i_div,
  input  wire        i_tx_start,
  input  wire [7:0]  i_tx_byte,
  input  wire        i_rx_pin,
  output reg         o_tx_pin,
  output reg         o_dat_out,
  output reg         o_dat_oe,
  output reg         o_tx_done,
  output reg         o_rx_done,
  output reg  [7:0]  o_rx_byte,
  output reg         o_rx9
);

  localparam ST_IDLE = 2'h0;
  localparam ST_TX   = 2'h1;
  localparam ST_RX   = 2'h2;
  localparam ST_SYNC = 2'h3;

  reg  [1:0]  tx_st_q;
  reg  [15:0] tx_cnt_q;
  reg  [3:0]  tx_bit_q;
  reg  [10:0] tx_sh_q;
  reg  [1:0]  rx_st_q;
  reg  [15:0] rx_cnt_q;
  reg  [3:0]  rx_bit_q;
  reg  [8:0]  rx_sh_q;
  reg  [2:0]  rx_sync_q;
  reg         rx_prev_q;
  reg  [7:0]  sy_sh_q;
  reg         sy_rx_q;
  wire        rx_in;
  wire        async_mode;
  wire        eleven;
  wire [15:0] sy_div;
  wire [3:0]  tx_last;
  wire [3:0]  rx_last;

  assign rx_in      = rx_sync_q[2];
  assign eleven     = (i_fmt == `USU_FMT_ELEVEN);
  assign async_mode = (i_fmt == `USU_FMT_TEN) || eleven;
  assign sy_div     = i_filt ? `USU_SYNC_DIV_FAST : `USU_SYNC_DIV_SLOW; // R8
  assign tx_last    = eleven ? 4'ha : 4'h9;
  assign rx_last    = eleven ? 4'h9 : 4'h8;

  // three-stage pin synchroniser, edge seen when stages 2 and 3 agree
  always @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      rx_sync_q <= 3'h7;
      rx_prev_q <= 1'b1;
    end
    else
    begin
      rx_sync_q <= {rx_sync_q[1:0], i_rx_pin};
      if (rx_sync_q[2] == rx_sync_q[1])
        rx_prev_q <= rx_sync_q[2];
    end
  end

  // transmitter: async frames and the synchronous shifter
  always @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      tx_st_q   <= ST_IDLE;
      tx_cnt_q  <= 16'h0000;
      tx_bit_q  <= 4'h0;
      tx_sh_q   <= 11'h7ff;
      sy_sh_q   <= 8'h00;
      sy_rx_q   <= 1'b0;
      o_tx_pin  <= 1'b1;
      o_dat_out <= 1'b1;
      o_dat_oe  <= 1'b0;
      o_tx_done <= 1'b0;
    end
    else
    begin
      o_tx_done <= 1'b0;
      case (tx_st_q)
        ST_IDLE:
        begin
          o_tx_pin <= 1'b1;
          o_dat_oe <= 1'b0;
          if (i_tx_start && i_active) // R1 R15
          begin
            tx_cnt_q <= 16'h0000;
            tx_bit_q <= 4'h0;
            if (async_mode)
            begin
              tx_st_q <= ST_TX;
              tx_sh_q <= eleven ? {1'b1, i_tx9, i_tx_byte, 1'b0} // R6 R10
                                : {2'h3, i_tx_byte, 1'b0}; // R5
            end
            else if (i_fmt == `USU_FMT_SYNC)
            begin
              tx_st_q   <= ST_SYNC; // R4
              sy_sh_q   <= i_tx_byte;
              sy_rx_q   <= i_rxen; // R9
              o_dat_oe  <= ~i_rxen;
              o_dat_out <= i_tx_byte[0];
            end
          end
        end
        ST_TX:
        begin
          o_tx_pin <= tx_sh_q[0]; // R2
          if (tx_cnt_q >= i_div - 16'h0001) // R13
          begin
            tx_cnt_q <= 16'h0000;
            tx_sh_q  <= {1'b1, tx_sh_q[10:1]};
            tx_bit_q <= tx_bit_q + 4'h1;
            if (tx_bit_q == tx_last)
            begin
              tx_st_q   <= ST_IDLE;
              o_tx_done <= 1'b1; // R18
            end
          end
          else
            tx_cnt_q <= tx_cnt_q + 16'h0001;
        end
        ST_SYNC:
        begin
          // shift clock low in first half, data taken at the rising edge
          tx_cnt_q <= tx_cnt_q + 16'h0001;
          o_tx_pin <= (tx_cnt_q >= {1'b0, sy_div[15:1]});
          if (tx_cnt_q == {1'b0, sy_div[15:1]} - 16'h0001 && sy_rx_q)
            sy_sh_q <= {rx_in, sy_sh_q[7:1]}; // R4
          if (tx_cnt_q == sy_div - 16'h0001)
          begin
            tx_cnt_q <= 16'h0000;
            if (!sy_rx_q)
              sy_sh_q <= {1'b0, sy_sh_q[7:1]};
            o_dat_out <= sy_sh_q[1];
            tx_bit_q  <= tx_bit_q + 4'h1;
            if (tx_bit_q == 4'h7)
            begin
              tx_st_q   <= ST_IDLE;
              o_dat_oe  <= 1'b0;
              o_tx_done <= ~sy_rx_q; // R18
            end
          end
        end
        default:
          tx_st_q <= ST_IDLE;
      endcase
    end
  end

  // receiver for the asynchronous modes
  always @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      rx_st_q   <= ST_IDLE;
      rx_cnt_q  <= 16'h0000;
      rx_bit_q  <= 4'h0;
      rx_sh_q   <= 9'h000;
      o_rx_done <= 1'b0;
      o_rx_byte <= `USU_RST_BYTE;
      o_rx9     <= 1'b0;
    end
    else
    begin
      o_rx_done <= 1'b0;
      // sync receive completes from the shifter
      if (tx_st_q == ST_SYNC && sy_rx_q && tx_bit_q == 4'h7
          && tx_cnt_q == sy_div - 16'h0001)
      begin
        o_rx_byte <= sy_sh_q; // R16
        o_rx_done <= 1'b1;
      end
      case (rx_st_q)
        ST_IDLE:
          if (i_active && async_mode && i_rxen && rx_prev_q && !rx_in
              && rx_sync_q[1] == rx_sync_q[2]) // R9 R17
          begin
            rx_st_q  <= ST_RX;
            rx_cnt_q <= 16'h0000;
            rx_bit_q <= 4'h0;
          end
        ST_RX:
        begin
          if (rx_cnt_q >= {1'b0, i_div[15:1]} && rx_bit_q == 4'h0)
          begin
            rx_cnt_q <= 16'h0000;
            rx_bit_q <= 4'h1;
            if (rx_in)
              rx_st_q <= ST_IDLE; // false start
          end
          else if (rx_bit_q != 4'h0 && rx_cnt_q >= i_div - 16'h0001) // R17
          begin
            rx_cnt_q <= 16'h0000;
            rx_bit_q <= rx_bit_q + 4'h1;
            if (rx_bit_q == rx_last + 4'h1)
            begin
              rx_st_q <= ST_IDLE;
              if (!eleven)
              begin
                o_rx_byte <= rx_sh_q[8:1];
                o_rx_done <= 1'b1;
              end
              else
              begin
                o_rx_byte <= rx_sh_q[7:0];
                o_rx9     <= rx_sh_q[8]; // R11
                o_rx_done <= ~i_filt | rx_sh_q[8]; // R7
              end
            end
            else
              rx_sh_q <= {rx_in, rx_sh_q[8:1]};
          end
          else
            rx_cnt_q <= rx_cnt_q + 16'h0001;
        end
        default:
          rx_st_q <= ST_IDLE;
      endcase
    end
  end

endmodule // usu_channel

`default_nettype wire

// *** rtl/usu_serial_port.v ***
// usu_serial_port.v: three uart channels behind an axi4-lite register slave
// assumes: one 10 MHz clock, synchronous reset, pins synchronised inside
//
// How it works
// R1: channel is uart when select equals 11
// R2: transmit pin carries tx, receive pin rx
// R3: each channel owns its baud generator
// R4: format 00: sync 8 bits, clock on tx
// R5: format 01: ten-bit async frame
// R6: format 11: eleven-bit frame, 10 reserved
// R7: filter set: receive flag only if ninth 1
// R8: sync mode: filter picks 1/12 or 1/4
// R9: receive only while receive enable set
// R10: transmit ninth bit sent in eleven-bit mode
// R11: received ninth bit stored in status
// R12: done flags sticky, cleared by writing one
// R13: async rate is clock over divisor
// R14: software keeps divisor above sixteen
// R15: data write loads shifter, starts frame
// R16: data read returns receive latch
// R17: start edge, mid-bit sampling, latch after stop
// R18: transmit done after last bit shifted
//
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
`include "usu_defines.vh"

module usu_serial_port
(
  input  wire        i_ref_clk,
  input  wire        i_rst,
  input  wire [11:0] i_awaddr,
  input  wire        i_awvalid,
  output reg         o_awready,
  input  wire [31:0] i_wdata,
  input  wire [3:0]  i_wstrb,
  input  wire        i_wvalid,
  output reg         o_wready,
  output reg  [1:0]  o_bresp,
  output reg         o_bvalid,
  input  wire        i_bready,
  input  wire [11:0] i_araddr,
  input  wire        i_arvalid,
  output reg         o_arready,
  output reg  [31:0] o_rdata,
  output reg  [1:0]  o_rresp,
  output reg         o_rvalid,
  input  wire        i_rready,
  input  wire [2:0]  i_uart_rx_line,
  output reg  [2:0]  o_uart_tx_line,
  output reg  [2:0]  o_uart_rx_line_out,
  output reg  [2:0]  o_uart_rx_line_oe
);

  reg  [7:0]  ctrl_q [0:2];
  reg  [7:0]  divisor_low_byte_q [0:2];
  reg  [7:0]  divisor_high_byte_q [0:2];
  reg  [5:0]  fsel_q;
  reg  [2:0]  tx_start_q;
  reg  [7:0]  tx_byte_q;
  reg         aw_got_q;
  reg         w_got_q;
  reg  [11:0] awaddr_q;
  reg  [31:0] wdata_q;
  reg         wstrb0_q;
  wire [2:0]  tx_pin;
  wire [2:0]  dat_out;
  wire [2:0]  dat_oe;
  wire [2:0]  tx_done;
  wire [2:0]  rx_done;
  wire [2:0]  rx9;
  wire [7:0]  rx_byte [0:2];
  wire [9:0]  widx;
  wire [9:0]  ridx;
  wire        wr_go;
  reg  [1:0]  wch;
  reg  [1:0]  wreg;
  reg  [1:0]  rch;
  reg  [1:0]  rreg;
  reg         w_fsel;
  reg         r_fsel;

  assign widx  = awaddr_q[11:2];
  assign ridx  = i_araddr[11:2];
  assign wr_go = aw_got_q && w_got_q && !o_bvalid;

  // decode a word index to channel and register slot (3 = none)
  always @*
  begin
    wch    = 2'h3;
    wreg   = 2'h0;
    w_fsel = (widx == {2'h0, `USU_IDX_FSEL});
    case (widx)
      {2'h0, `USU_IDX_CTRL0}:  begin wch = 2'h0; wreg = 2'h0; end
      {2'h0, `USU_IDX_BAUDL0}: begin wch = 2'h0; wreg = 2'h1; end
      {2'h0, `USU_IDX_BAUDH0}: begin wch = 2'h0; wreg = 2'h2; end
      {2'h0, `USU_IDX_DATA0}:  begin wch = 2'h0; wreg = 2'h3; end
      {2'h0, `USU_IDX_CTRL1}:  begin wch = 2'h1; wreg = 2'h0; end
      {2'h0, `USU_IDX_BAUDL1}: begin wch = 2'h1; wreg = 2'h1; end
      {2'h0, `USU_IDX_BAUDH1}: begin wch = 2'h1; wreg = 2'h2; end
      {2'h0, `USU_IDX_DATA1}:  begin wch = 2'h1; wreg = 2'h3; end
      {2'h0, `USU_IDX_CTRL2}:  begin wch = 2'h2; wreg = 2'h0; end
      {2'h0, `USU_IDX_BAUDL2}: begin wch = 2'h2; wreg = 2'h1; end
      {2'h0, `USU_IDX_BAUDH2}: begin wch = 2'h2; wreg = 2'h2; end
      {2'h0, `USU_IDX_DATA2}:  begin wch = 2'h2; wreg = 2'h3; end
      default:                 begin wch = 2'h3; wreg = 2'h0; end
    endcase
  end

  always @*
  begin
    rch    = 2'h3;
    rreg   = 2'h0;
    r_fsel = (ridx == {2'h0, `USU_IDX_FSEL});
    case (ridx)
      {2'h0, `USU_IDX_CTRL0}:  begin rch = 2'h0; rreg = 2'h0; end
      {2'h0, `USU_IDX_BAUDL0}: begin rch = 2'h0; rreg = 2'h1; end
      {2'h0, `USU_IDX_BAUDH0}: begin rch = 2'h0; rreg = 2'h2; end
      {2'h0, `USU_IDX_DATA0}:  begin rch = 2'h0; rreg = 2'h3; end
      {2'h0, `USU_IDX_CTRL1}:  begin rch = 2'h1; rreg = 2'h0; end
      {2'h0, `USU_IDX_BAUDL1}: begin rch = 2'h1; rreg = 2'h1; end
      {2'h0, `USU_IDX_BAUDH1}: begin rch = 2'h1; rreg = 2'h2; end
      {2'h0, `USU_IDX_DATA1}:  begin rch = 2'h1; rreg = 2'h3; end
      {2'h0, `USU_IDX_CTRL2}:  begin rch = 2'h2; rreg = 2'h0; end
      {2'h0, `USU_IDX_BAUDL2}: begin rch = 2'h2; rreg = 2'h1; end
      {2'h0, `USU_IDX_BAUDH2}: begin rch = 2'h2; rreg = 2'h2; end
      {2'h0, `USU_IDX_DATA2}:  begin rch = 2'h2; rreg = 2'h3; end
      default:                 begin rch = 2'h3; rreg = 2'h0; end
    endcase
  end

  // write channel: address and data taken in either order
  always @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      o_awready <= 1'b0;
      o_wready  <= 1'b0;
      aw_got_q  <= 1'b0;
      w_got_q   <= 1'b0;
      awaddr_q  <= 12'h000;
      wdata_q   <= 32'h00000000;
      wstrb0_q  <= 1'b0;
      o_bvalid  <= 1'b0;
      o_bresp   <= `USU_RESP_OKAY;
      fsel_q    <= 6'h00;
    end
    else
    begin
      o_awready <= !aw_got_q && !o_awready && i_awvalid;
      o_wready  <= !w_got_q && !o_wready && i_wvalid;
      if (o_awready && i_awvalid)
      begin
        aw_got_q <= 1'b1;
        awaddr_q <= i_awaddr;
      end
      if (o_wready && i_wvalid)
      begin
        w_got_q  <= 1'b1;
        wdata_q  <= i_wdata;
        wstrb0_q <= i_wstrb[0];
      end
      if (wr_go)
      begin
        aw_got_q <= 1'b0;
        w_got_q  <= 1'b0;
        o_bvalid <= 1'b1;
        o_bresp  <= (wch == 2'h3 && !w_fsel) ? `USU_RESP_SLVERR : `USU_RESP_OKAY;
        if (w_fsel && wstrb0_q)
          fsel_q <= wdata_q[5:0];
      end
      else if (o_bvalid && i_bready)
        o_bvalid <= 1'b0;
    end
  end

  // per-channel registers and channel cores
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1)
    begin : g_ch
      wire wr_me;
      assign wr_me = wr_go && wstrb0_q && (wch == g);

      always @(posedge i_ref_clk)
      begin
        if (i_rst)
        begin
          ctrl_q[g]     <= `USU_RST_BYTE;
          divisor_low_byte_q[g]    <= `USU_RST_BYTE;
          divisor_high_byte_q[g]    <= `USU_RST_BYTE;
          tx_start_q[g] <= 1'b0;
        end
        else
        begin
          tx_start_q[g] <= wr_me && (wreg == 2'h3); // R15
          if (wr_me && wreg == 2'h1)
            divisor_low_byte_q[g] <= wdata_q[7:0];
          if (wr_me && wreg == 2'h2)
            divisor_high_byte_q[g] <= wdata_q[7:0];
          if (wr_me && wreg == 2'h0)
          begin
            ctrl_q[g][7:3] <= wdata_q[7:3];
            ctrl_q[g][`USU_B_RX9] <= wdata_q[`USU_B_RX9];
          end
          if (rx_done[g])
            ctrl_q[g][`USU_B_RX9] <= rx9[g]; // R11
          // set wins over a write-one clear in the same cycle
          if (tx_done[g])
            ctrl_q[g][`USU_B_TXDONE] <= 1'b1; // R12
          else if (wr_me && wreg == 2'h0 && wdata_q[`USU_B_TXDONE])
            ctrl_q[g][`USU_B_TXDONE] <= 1'b0; // R12
          if (rx_done[g])
            ctrl_q[g][`USU_B_RXDONE] <= 1'b1; // R12
          else if (wr_me && wreg == 2'h0 && wdata_q[`USU_B_RXDONE])
            ctrl_q[g][`USU_B_RXDONE] <= 1'b0; // R12
        end
      end

      // own divisor per channel
      usu_channel u_ch
      (
        .i_ref_clk  (i_ref_clk),
        .i_rst      (i_rst),
        .i_active   (fsel_q[2*g+1:2*g] == `USU_FSEL_UART), // R1
        .i_fmt      (ctrl_q[g][`USU_B_FMT_HI:`USU_B_FMT_LO]),
        .i_filt     (ctrl_q[g][`USU_B_FILT]),
        .i_rxen     (ctrl_q[g][`USU_B_RXEN]),
        .i_tx9      (ctrl_q[g][`USU_B_TX9]),
        .i_div      ({divisor_high_byte_q[g], divisor_low_byte_q[g]}), // R3 R13
        .i_tx_start (tx_start_q[g]),
        .i_tx_byte  (tx_byte_q),
        .i_rx_pin   (i_uart_rx_line[g]),
        .o_tx_pin   (tx_pin[g]),
        .o_dat_out  (dat_out[g]),
        .o_dat_oe   (dat_oe[g]),
        .o_tx_done  (tx_done[g]),
        .o_rx_done  (rx_done[g]),
        .o_rx_byte  (rx_byte[g]),
        .o_rx9      (rx9[g])
      );
    end
  endgenerate

  // output pins registered once more
  always @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      tx_byte_q          <= 8'h00;
      o_uart_tx_line     <= 3'h7;
      o_uart_rx_line_out <= 3'h7;
      o_uart_rx_line_oe  <= 3'h0;
    end
    else
    begin
      if (wr_go)
        tx_byte_q <= wdata_q[7:0];
      o_uart_tx_line     <= tx_pin; // R2
      o_uart_rx_line_out <= dat_out;
      o_uart_rx_line_oe  <= dat_oe;
    end
  end

  // read channel: one read at a time, answer one cycle after acceptance
  always @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      o_arready <= 1'b0;
      o_rvalid  <= 1'b0;
      o_rdata   <= 32'h00000000;
      o_rresp   <= `USU_RESP_OKAY;
    end
    else
    begin
      o_arready <= !o_arready && !o_rvalid && i_arvalid;
      if (o_arready && i_arvalid)
      begin
        o_rvalid <= 1'b1;
        o_rresp  <= `USU_RESP_OKAY;
        o_rdata  <= 32'h00000000;
        if (r_fsel)
          o_rdata <= {26'h0, fsel_q};
        else if (rch == 2'h3)
          o_rresp <= `USU_RESP_SLVERR;
        else if (rreg == 2'h0)
          o_rdata <= {24'h000000, ctrl_q[rch]};
        else if (rreg == 2'h1)
          o_rdata <= {24'h000000, divisor_low_byte_q[rch]};
        else if (rreg == 2'h2)
          o_rdata <= {24'h000000, divisor_high_byte_q[rch]};
        else
          o_rdata <= {24'h000000, rx_byte[rch]}; // R16
      end
      else if (o_rvalid && i_rready)
        o_rvalid <= 1'b0;
    end
  end

endmodule // usu_serial_port

`default_nettype wire

// *** sim/usu_serial_port_assertions.sv ***
// usu_serial_port_assertions.sv: port checker for the serial port
// assumes: bench keeps channel 0 in async modes with divisor BIT_CYC
`timescale 1ns/100ps
`default_nettype none
module usu_serial_port_checker
#(
  parameter int BIT_CYC = 17
)
(
  input wire logic        i_ref_clk,
  input wire logic        i_rst,
  input wire logic        o_awready,
  input wire logic        o_wready,
  input wire logic [1:0]  o_bresp,
  input wire logic        o_bvalid,
  input wire logic        i_bready,
  input wire logic        i_arvalid,
  input wire logic        o_arready,
  input wire logic [31:0] o_rdata,
  input wire logic        o_rvalid,
  input wire logic        i_rready,
  input wire logic [2:0]  o_uart_tx_line,
  input wire logic [2:0]  o_uart_rx_line_oe
);
  logic [15:0] lo_q;
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_rst);
  // length of the current low run on channel 0 transmit line
  always @(posedge i_ref_clk)
  begin
    if (i_rst || o_uart_tx_line[0])
      lo_q <= 16'h0000;
    else
      lo_q <= lo_q + 16'h0001;
  end
  chk_aw_pulse: assert property (o_awready |=> !o_awready)
    else $error("write address ready held too long");
  chk_b_hold: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
    else $error("write response dropped early");
  chk_b_cause: assert property ($rose(o_bvalid) |-> $past(o_awready || o_wready, 2))
    else $error("write response without handshake");
  chk_r_hold: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
    else $error("read data dropped early");
  chk_r_answer: assert property (i_arvalid && o_arready |=> o_rvalid)
    else $error("read answer late");
  chk_idle_line: assert property ($fell(i_rst) |-> o_uart_tx_line == 3'h7
    && o_uart_rx_line_oe == 3'h0)
    else $error("lines not idle after reset");
  chk_bit_time: assert property ($rose(o_uart_tx_line[0]) |-> lo_q != 16'h0000
    && lo_q % BIT_CYC == 0)
    else $error("low run not whole bit times");
  chk_async_oe: assert property (o_uart_rx_line_oe[0] == 1'b0)
    else $error("async channel drives its receive pin");
endmodule // usu_serial_port_checker
bind usu_serial_port usu_serial_port_checker i_chk (.i_ref_clk, .i_rst, .o_awready, .o_wready,
  .o_bresp, .o_bvalid, .i_bready, .i_arvalid, .o_arready, .o_rdata, .o_rvalid, .i_rready,
  .o_uart_tx_line, .o_uart_rx_line_oe);
`default_nettype wire

// *** sim/usu_far_device.sv ***
// usu_far_device.sv: external serial device on channel 0
// assumes: bit time counted in reference clocks, line idle high
`timescale 1ns/100ps
`default_nettype none
module usu_far_device
#(
  parameter int BIT_CYC = 17
)
(
  input  wire logic i_ref_clk,
  input  wire logic i_line,
  output var  logic o_line
);
  logic       nine = 1'b0;
  logic [8:0] got_q [$];
  initial o_line = 1'b1;
  // start, data lsb first, optional ninth, stop
  task automatic send(input logic [8:0] v);
    int i;
    @(posedge i_ref_clk);
    o_line <= 1'b0;
    repeat (BIT_CYC) @(posedge i_ref_clk);
    for (i = 0; i < (nine ? 9 : 8); i++)
    begin
      o_line <= v[i];
      repeat (BIT_CYC) @(posedge i_ref_clk);
    end
    o_line <= 1'b1;
    repeat (BIT_CYC) @(posedge i_ref_clk);
  endtask
  // receiver, samples mid bit
  always
  begin : rx_frame
    logic [8:0] v;
    int i;
    @(negedge i_line);
    v = 9'h000;
    repeat (BIT_CYC / 2) @(posedge i_ref_clk);
    for (i = 0; i < (nine ? 9 : 8); i++)
    begin
      repeat (BIT_CYC) @(posedge i_ref_clk);
      v[i] = i_line;
    end
    repeat (BIT_CYC) @(posedge i_ref_clk);
    got_q.push_back(v);
  end
endmodule // usu_far_device
`default_nettype wire

// *** sim/tb.sv ***
// tb.sv: self-checking bench for the three-channel serial port
// assumes: design, far device and checker compiled first
`timescale 1ns/100ps
`default_nettype none
`include "usu_defines.vh"
module tb;
  localparam logic [7:0] DIV = 8'h11;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0]  wstrb = 4'h1;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, far_line;
  logic [1:0]  bresp, rresp, resp;
  logic [31:0] rdata, rd_d;
  logic [2:0]  txl, rxo, rxoe;
  wire  [2:0]  rxl = {1'b1, rxoe[1] ? rxo[1] : 1'b1, rxoe[0] ? rxo[0] : far_line};
  int          error_cnt = 0;
  int          n_tests = 0;
  int          cyc = 0;
  logic [7:0]  regs [13] = '{`USU_IDX_CTRL0, `USU_IDX_BAUDL0, `USU_IDX_BAUDH0, `USU_IDX_DATA0,
    `USU_IDX_CTRL1, `USU_IDX_BAUDL1, `USU_IDX_BAUDH1, `USU_IDX_DATA1, `USU_IDX_CTRL2,
    `USU_IDX_BAUDL2, `USU_IDX_BAUDH2, `USU_IDX_DATA2, `USU_IDX_FSEL};
  always #50 clk = ~clk;
  usu_serial_port i_usu_serial_port
  (
    .i_ref_clk          (clk),
    .i_rst              (rst),
    .i_awaddr           (awaddr),
    .i_awvalid          (awvalid),
    .o_awready          (awready),
    .i_wdata            (wdata),
    .i_wstrb            (wstrb),
    .i_wvalid           (wvalid),
    .o_wready           (wready),
    .o_bresp            (bresp),
    .o_bvalid           (bvalid),
    .i_bready           (bready),
    .i_araddr           (araddr),
    .i_arvalid          (arvalid),
    .o_arready          (arready),
    .o_rdata            (rdata),
    .o_rresp            (rresp),
    .o_rvalid           (rvalid),
    .i_rready           (rready),
    .i_uart_rx_line     (rxl),
    .o_uart_tx_line     (txl),
    .o_uart_rx_line_out (rxo),
    .o_uart_rx_line_oe  (rxoe)
  );
  usu_far_device #(.BIT_CYC(17)) i_usu_far_device
    (.i_ref_clk(clk), .i_line(txl[0]), .o_line(far_line));
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e)
    begin
      error_cnt++;
      $display("ERROR %0t ns: saw %h, expected %h", $time, s, e);
    end
  endtask
  task automatic complete_run;
    if (error_cnt == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic w(input logic [7:0] ix, input logic [7:0] d);
    @(posedge clk);
    awaddr  <= {2'b00, ix, 2'b00};
    wdata   <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
      if (bvalid && !bready)
        bready <= 1'b1;
    end
    while (bvalid !== 1'b1 || bready !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] ix);
    @(posedge clk);
    araddr  <= {2'b00, ix, 2'b00};
    arvalid <= 1'b1;
    do
    begin
      @(posedge clk);
      if (arready)
        arvalid <= 1'b0;
      if (rvalid && !rready)
        rready <= 1'b1;
    end
    while (rvalid !== 1'b1 || rready !== 1'b1);
    rd_d = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] ix, input logic [31:0] e);
    rd(ix);
    chk(rd_d, e);
  endtask
  task automatic wait_flag(input logic [7:0] ix, input int b);
    do rd(ix); while (rd_d[b] !== 1'b1);
  endtask
  task automatic far_chk(input logic [8:0] e);
    do @(posedge clk); while (i_usu_far_device.got_q.size() == 0);
    chk(i_usu_far_device.got_q.pop_front(), e);
  endtask
  // shift clock on tx, data on rx pin sampled at clock rise
  task automatic sync_mon(input logic f);
    logic [7:0] v;
    int i, t0;
    for (i = 0; i < 8; i++)
    begin
      do @(posedge clk); while (txl[1] !== 1'b0);
      if (i > 0)
        chk(cyc - t0, f ? 4 : 12);
      t0 = cyc;
      do @(posedge clk); while (txl[1] !== 1'b1);
      v[i] = rxl[1];
    end
    chk(v, 8'h96);
  endtask
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      error_cnt++;
      complete_run;
    end
  end
  initial
  begin
    logic [31:0] x;
    int k;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    foreach (regs[k]) rd_chk(regs[k], 32'h0);
    rd(8'h01);
    chk(resp, `USU_RESP_SLVERR);
    w(8'h01, 8'hff);
    chk(resp, `USU_RESP_SLVERR);
    w(`USU_IDX_FSEL, 8'h0f);
    w(`USU_IDX_BAUDL0, DIV);
    rd_chk(`USU_IDX_BAUDL0, DIV);
    w(`USU_IDX_CTRL0, 8'h50);
    w(`USU_IDX_DATA0, 8'ha5);
    far_chk(9'h0a5);
    wait_flag(`USU_IDX_CTRL0, 1);
    w(`USU_IDX_CTRL0, 8'h50);
    rd_chk(`USU_IDX_CTRL0, 8'h52);
    w(`USU_IDX_CTRL0, 8'h52);
    rd_chk(`USU_IDX_CTRL0, 8'h50);
    i_usu_far_device.send(9'h03c);
    wait_flag(`USU_IDX_CTRL0, 0);
    rd_chk(`USU_IDX_DATA0, 8'h3c);
    w(`USU_IDX_CTRL0, 8'h41);
    i_usu_far_device.send(9'h077);
    repeat (20) @(posedge clk);
    rd_chk(`USU_IDX_CTRL0, 8'h40);
    rd_chk(`USU_IDX_DATA0, 8'h3c);
    i_usu_far_device.nine = 1'b1;
    for (k = 0; k < 2; k++)
    begin
      x = 8'hc0 | (k << 3);
      w(`USU_IDX_CTRL0, x[7:0]);
      w(`USU_IDX_DATA0, 8'h5a);
      far_chk({k[0], 8'h5a});
      wait_flag(`USU_IDX_CTRL0, 1);
      w(`USU_IDX_CTRL0, x[7:0] | 8'h02);
    end
    for (k = 0; k < 3; k++)
    begin
      x = (k < 2) ? 8'hf0 : 8'hd0;
      w(`USU_IDX_CTRL0, x[7:0]);
      i_usu_far_device.send({k == 1, 8'h30});
      repeat (20) @(posedge clk);
      rd(`USU_IDX_CTRL0);
      chk(rd_d[0], k != 0);
      chk(rd_d[2], k == 1);
      w(`USU_IDX_CTRL0, x[7:0] | 8'h01);
    end
    for (k = 0; k < 2; k++)
    begin
      x = k << 5;
      w(`USU_IDX_CTRL1, x[7:0]);
      fork
        sync_mon(k[0]);
        w(`USU_IDX_DATA1, 8'h96);
      join
      wait_flag(`USU_IDX_CTRL1, 1);
      w(`USU_IDX_CTRL1, x[7:0] | 8'h02);
    end
    w(`USU_IDX_CTRL1, 8'h10);
    w(`USU_IDX_DATA1, 8'h00);
    wait_flag(`USU_IDX_CTRL1, 0);
    rd_chk(`USU_IDX_CTRL1, 8'h11);
    rd_chk(`USU_IDX_DATA1, 8'hff);
    w(`USU_IDX_BAUDL2, DIV);
    w(`USU_IDX_CTRL2, 8'h40);
    w(`USU_IDX_DATA2, 8'h11);
    x = 0;
    repeat (60)
    begin
      @(posedge clk);
      x = x | !txl[2];
    end
    chk(x, 0);
    complete_run;
  end
endmodule // tb
`default_nettype wire
